// *** core/switch_glb_pkg.sv ***
/*
  Constants for the global control and interrupt summary register group:
  byte addresses, field positions, reset values, serial frame layout and
  serial clock rate threshold.
  Assumes byte-addressed access with big-endian multi-byte registers.
*/
package switch_glb_pkg;

  // Byte addresses of the first byte of each register
  localparam logic [15:0] ADDR_PWR_CTL   = 16'h0006;
  localparam logic [15:0] ADDR_VARIANT   = 16'h000F;
  localparam logic [15:0] ADDR_GLB_STAT  = 16'h0010;
  localparam logic [15:0] ADDR_GLB_MASK  = 16'h0014;
  localparam logic [15:0] ADDR_PORT_STAT = 16'h0018;
  localparam logic [15:0] ADDR_PORT_MASK = 16'h001C;
  localparam logic [15:0] ADDR_SIO_CTL   = 16'h0100;

  // Field positions
  localparam int PWR_EN_BIT   = 1;
  localparam int PWR_POL_BIT  = 0;
  localparam int GLB_LE_BIT   = 31;
  localparam int SIO_PRE_BIT  = 2;
  localparam int SIO_AUTO_BIT = 1;
  localparam int SIO_RISE_BIT = 0;
  localparam int NUM_PORTS    = 3;

  // Reset values
  localparam logic [1:0] PWR_CTL_RST   = 2'h0;
  localparam logic       GLB_MASK_RST  = 1'b0;
  localparam logic [2:0] PORT_MASK_RST = 3'h0;
  localparam logic [7:0] SIO_CTL_RST   = 8'h42;

  // Serial frame: bit 23 read flag, bits 15:0 byte address, then data
  localparam logic [4:0] HDR_LAST  = 5'h17;
  localparam logic [4:0] BYTE_LAST = 5'h07;
  localparam int         HDR_RD_POS = 22;

  // Serial clock rate threshold for automatic launch edge
  localparam int         REF_CLK_PERIOD_NS   = 10;
  localparam int         SCLK_FAST_PERIOD_NS = 40;
  localparam logic [3:0] SCLK_FAST_CYC =
    4'(SCLK_FAST_PERIOD_NS / REF_CLK_PERIOD_NS);

endpackage

// *** core/reg_access_if.sv ***
/*
  Byte access channel between the serial byte engine and the register bank.
  Assumes both ends run on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

interface reg_access_if;
  logic        acc_valid;
  logic        acc_write;
  logic [15:0] acc_addr;
  logic [7:0]  acc_wdata;
  logic [7:0]  rd_data;
  logic        launch_rise;
  logic        sclk_rise;

  modport engine (output acc_valid, output acc_write, output acc_addr, output acc_wdata,
                  output sclk_rise, input rd_data, input launch_rise);
  modport bank   (input acc_valid, input acc_write, input acc_addr, input acc_wdata,
                  input sclk_rise, output rd_data, output launch_rise);
endinterface

`default_nettype wire

// *** core/serial_byte_engine.sv ***
/*
  Serial slave byte engine: synchronises the serial pins, collects the
  24-bit header and data bytes, issues byte accesses and shifts read data.
  Assumes the serial clock is far slower than ref_clk and chip select low
  frames each transfer.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_byte_engine
  import switch_glb_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic arst_n,
  // Serial pins
  input  wire logic spi_sclk,
  input  wire logic spi_cs_n,
  input  wire logic spi_sdi,
  output logic      serial_data_out,
  output logic      serial_data_out_oe,
  // Byte access channel
  reg_access_if.engine acc
);

  logic        sclk_meta_reg, sclk_sync_reg, sclk_prev_reg;
  logic        sclk_meta_next, sclk_sync_next, sclk_prev_next;
  logic        cs_meta_reg, cs_sync_reg, sdi_meta_reg, sdi_sync_reg;
  logic        cs_meta_next, cs_sync_next, sdi_meta_next, sdi_sync_next;
  logic [22:0] hdr_reg, hdr_next;
  logic [7:0]  rx_reg, rx_next, tx_reg, tx_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic        in_data_reg, in_data_next, is_read_reg, is_read_next;
  logic [15:0] addr_reg, addr_next, acc_addr_reg, acc_addr_next;
  logic        valid_reg, valid_next, write_reg, write_next;
  logic [7:0]  wdata_reg, wdata_next;
  logic        out_reg, out_next, oe_reg, oe_next, rise_reg, rise_next;
  logic        rise, fall, active;
  logic [15:0] hdr_addr;

  // Frame decode and shifting; first sync stage only feeds the second
  always_comb
  begin
    sclk_meta_next = spi_sclk;
    sclk_sync_next = sclk_meta_reg;
    sclk_prev_next = sclk_sync_reg;
    cs_meta_next   = spi_cs_n;
    cs_sync_next   = cs_meta_reg;
    sdi_meta_next  = spi_sdi;
    sdi_sync_next  = sdi_meta_reg;
    rise     = sclk_sync_reg & ~sclk_prev_reg;
    fall     = ~sclk_sync_reg & sclk_prev_reg;
    active   = ~cs_sync_reg;
    hdr_addr = {hdr_reg[14:0], sdi_sync_reg};
    hdr_next = hdr_reg;
    rx_next  = rx_reg;
    tx_next  = tx_reg;
    cnt_next = cnt_reg;
    in_data_next  = in_data_reg;
    is_read_next  = is_read_reg;
    addr_next     = addr_reg;
    acc_addr_next = acc_addr_reg;
    wdata_next    = wdata_reg;
    write_next    = write_reg;
    valid_next    = 1'b0;
    out_next      = out_reg;
    oe_next       = active;
    rise_next     = rise;
    if (!active)
    begin
      cnt_next     = 5'h00;
      in_data_next = 1'b0;
    end
    else
    begin
      if (rise && !in_data_reg)
      begin
        hdr_next = {hdr_reg[21:0], sdi_sync_reg};
        cnt_next = cnt_reg + 5'h01;
        if (cnt_reg == HDR_LAST)
        begin
          cnt_next      = 5'h00;
          in_data_next  = 1'b1;
          is_read_next  = hdr_reg[HDR_RD_POS];
          addr_next     = hdr_addr;
          if (hdr_reg[HDR_RD_POS])
          begin
            valid_next    = 1'b1;
            write_next    = 1'b0;
            acc_addr_next = hdr_addr;
            addr_next     = hdr_addr + 16'h0001;
          end
        end
      end
      else if (rise)
      begin
        rx_next  = {rx_reg[6:0], sdi_sync_reg};
        cnt_next = cnt_reg + 5'h01;
        // Boundary edge is skipped so the reload launches the next MSB
        if (is_read_reg && acc.launch_rise && cnt_reg != BYTE_LAST)
        begin
          out_next = tx_reg[7];
          tx_next  = {tx_reg[6:0], 1'b0};
        end
        if (cnt_reg == BYTE_LAST)
        begin
          cnt_next      = 5'h00;
          valid_next    = 1'b1;
          write_next    = ~is_read_reg;
          wdata_next    = {rx_reg[6:0], sdi_sync_reg};
          acc_addr_next = addr_reg;
          addr_next     = addr_reg + 16'h0001;
        end
      end
      if (fall && in_data_reg && is_read_reg && !acc.launch_rise)
      begin
        out_next = tx_reg[7];
        tx_next  = {tx_reg[6:0], 1'b0};
      end
      if (valid_reg && !write_reg)
      begin
        if (acc.launch_rise)
        begin
          out_next = acc.rd_data[7];
          tx_next  = {acc.rd_data[6:0], 1'b0};
        end
        else
        begin
          tx_next = acc.rd_data;
        end
      end
    end
  end

  // Registers only
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclk_meta_reg <= 1'b0; sclk_sync_reg <= 1'b0; sclk_prev_reg <= 1'b0;
      cs_meta_reg   <= 1'b1; cs_sync_reg   <= 1'b1;
      sdi_meta_reg  <= 1'b0; sdi_sync_reg  <= 1'b0;
      hdr_reg <= 23'h00_0000; rx_reg <= 8'h00; tx_reg <= 8'h00; cnt_reg <= 5'h00;
      in_data_reg <= 1'b0; is_read_reg <= 1'b0; addr_reg <= 16'h0000;
      acc_addr_reg <= 16'h0000; valid_reg <= 1'b0; write_reg <= 1'b0; wdata_reg <= 8'h00;
      out_reg <= 1'b0; oe_reg <= 1'b0; rise_reg <= 1'b0;
    end
    else
    begin
      sclk_meta_reg <= sclk_meta_next; sclk_sync_reg <= sclk_sync_next; sclk_prev_reg <= sclk_prev_next;
      cs_meta_reg   <= cs_meta_next;   cs_sync_reg   <= cs_sync_next;
      sdi_meta_reg  <= sdi_meta_next;  sdi_sync_reg  <= sdi_sync_next;
      hdr_reg <= hdr_next; rx_reg <= rx_next; tx_reg <= tx_next; cnt_reg <= cnt_next;
      in_data_reg <= in_data_next; is_read_reg <= is_read_next; addr_reg <= addr_next;
      acc_addr_reg <= acc_addr_next; valid_reg <= valid_next; write_reg <= write_next; wdata_reg <= wdata_next;
      out_reg <= out_next; oe_reg <= oe_next; rise_reg <= rise_next;
    end
  end

  // Channel and pin outputs straight from flops
  assign acc.acc_valid       = valid_reg;
  assign acc.acc_write       = write_reg;
  assign acc.acc_addr        = acc_addr_reg;
  assign acc.acc_wdata       = wdata_reg;
  assign acc.sclk_rise       = rise_reg;
  assign serial_data_out     = out_reg;
  assign serial_data_out_oe  = oe_reg;

endmodule

`default_nettype wire

// *** core/global_irq_serial_ctrl.sv ***
/*
  Global control register group of a three-port switch: power event pin
  control, product variant code, two-level interrupt summary with masks,
  and serial I/O options. Registers are reached byte-wise over the serial
  host port.
  Assumes lookup-engine and per-port interrupt levels come from logic on
  ref_clk; serial pins are asynchronous and synchronised in the engine.
*/
`timescale 1ns/1ps
`default_nettype none

// Function
// - Power event pin driven only when enabled
// - Polarity bit: 0 active low, 1 high
// - Read-only product variant byte at 0x000F
// - Global status bit 31 mirrors lookup engine
// - Global mask bit 31: 0 enables interrupt
// - Port summary flags in bits 2:0
// - Port mask bits 2:0, 0 enables
// - Port flag follows port pending interrupts
// - Unused status and mask bits ignore writes
// - Preamble suppression bit accepts preambleless frames
// - Preamble suppression affects management interface only
// - Auto edge: rising when serial clock fast
// - Manual edge bit 0 selects launch edge
// - Registers reached byte-wise over serial port
// - Big-endian, bytes accessible in any order
module global_irq_serial_ctrl
  import switch_glb_pkg::*;
#(
  parameter logic [7:0] PRODUCT_VARIANT = 8'h5A  // Arbitrary value
)
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Serial host port
  input  wire logic       spi_sclk,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_sdi,
  output logic            serial_data_out,
  output logic            serial_data_out_oe,
  // Interrupt sources and power event request from switch logic
  input  wire logic       lookup_engine_irq,
  input  wire logic [2:0] port_irq_pending,
  input  wire logic       power_event_req,
  // Outputs to pins and management logic
  output logic            irq_n,
  output logic            power_event_pin,
  output logic            power_event_pin_oe,
  output logic            preamble_suppress
);

  reg_access_if acc ();

  // Writable control state
  logic [1:0] pwr_ctl_reg, pwr_ctl_next;
  logic       glb_mask_reg, glb_mask_next;
  logic [2:0] port_mask_reg, port_mask_next;
  logic [7:0] sio_ctl_reg, sio_ctl_next;

  // Status and pin state
  logic       le_stat_reg, le_stat_next;
  logic [2:0] port_stat_reg, port_stat_next;
  logic       irq_n_reg, irq_n_next;
  logic       pwr_pin_reg, pwr_pin_next;
  logic       pwr_oe_reg, pwr_oe_next;
  logic       preamble_reg, preamble_next;

  // Serial clock rate detection and launch edge
  logic [3:0] per_cnt_reg, per_cnt_next;
  logic       fast_reg, fast_next;
  logic       launch_rise_reg, launch_rise_next;

  // Read path
  logic [31:0] glb_stat_word, glb_mask_word, port_stat_word, port_mask_word;
  logic [7:0]  rd_data_c;
  logic        wr_en;

  // Byte lane of a 32-bit word, lane 0 holds the most significant byte
  function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [1:0] lane);
    logic [7:0] b;
    b = 8'h00;
    unique case (lane)
      2'h0: b = w[31:24];
      2'h1: b = w[23:16];
      2'h2: b = w[15:8];
      2'h3: b = w[7:0];
    endcase
    return b;
  endfunction

  // Address of the containing word, for matching a byte to its register
  function automatic logic [15:0] word_base(input logic [15:0] a);
    return {a[15:2], 2'h0};
  endfunction

  serial_byte_engine u_engine (
    .ref_clk            (ref_clk),
    .arst_n             (arst_n),
    .spi_sclk           (spi_sclk),
    .spi_cs_n           (spi_cs_n),
    .spi_sdi            (spi_sdi),
    .serial_data_out    (serial_data_out),
    .serial_data_out_oe (serial_data_out_oe),
    .acc                (acc.engine)
  );

  // Register contents as full words; reserved bits read as zero
  always_comb
  begin
    glb_stat_word              = 32'h0000_0000;
    glb_stat_word[GLB_LE_BIT]  = le_stat_reg;
    glb_mask_word              = 32'h0000_0000;
    glb_mask_word[GLB_LE_BIT]  = glb_mask_reg;
    port_stat_word             = {29'h0000_0000, port_stat_reg};
    port_mask_word             = {29'h0000_0000, port_mask_reg};
  end

  // Byte read decode; unmapped addresses return zero
  always_comb
  begin
    rd_data_c = 8'h00;
    if (acc.acc_addr == ADDR_PWR_CTL)
    begin
      rd_data_c = {6'h00, pwr_ctl_reg};
    end
    else if (acc.acc_addr == ADDR_VARIANT)
    begin
      rd_data_c = PRODUCT_VARIANT;
    end
    else if (acc.acc_addr == ADDR_SIO_CTL)
    begin
      rd_data_c = sio_ctl_reg;
    end
    // Word registers by lane
    else if (word_base(acc.acc_addr) == ADDR_GLB_STAT)
    begin
      rd_data_c = word_byte(glb_stat_word, acc.acc_addr[1:0]);
    end
    else if (word_base(acc.acc_addr) == ADDR_GLB_MASK)
    begin
      rd_data_c = word_byte(glb_mask_word, acc.acc_addr[1:0]);
    end
    else if (word_base(acc.acc_addr) == ADDR_PORT_STAT)
    begin
      rd_data_c = word_byte(port_stat_word, acc.acc_addr[1:0]);
    end
    else if (word_base(acc.acc_addr) == ADDR_PORT_MASK)
    begin
      rd_data_c = word_byte(port_mask_word, acc.acc_addr[1:0]);
    end
  end

  assign acc.rd_data = rd_data_c;

  // Byte writes; documented writable bits take data, and every bit of the serial I/O control byte
  always_comb
  begin
    wr_en          = acc.acc_valid & acc.acc_write;
    pwr_ctl_next   = pwr_ctl_reg;
    glb_mask_next  = glb_mask_reg;
    port_mask_next = port_mask_reg;
    sio_ctl_next   = sio_ctl_reg;
    if (wr_en)
    begin
      // Only enable and polarity stored
      if (acc.acc_addr == ADDR_PWR_CTL)
      begin
        pwr_ctl_next = acc.acc_wdata[1:0];
      end
      // Bit 31 lives in the lowest byte address of the word
      if (acc.acc_addr == ADDR_GLB_MASK)
      begin
        glb_mask_next = acc.acc_wdata[7];
      end
      // Other lanes of both pairs hold only reserved bits
      if (acc.acc_addr == ADDR_PORT_MASK + 16'h0003)
      begin
        port_mask_next = acc.acc_wdata[2:0];
      end
      // Reserved upper bits stay writable so a read-merge-write holds them
      if (acc.acc_addr == ADDR_SIO_CTL)
      begin
        sio_ctl_next = acc.acc_wdata;
      end
    end
  end

  // Status capture and interrupt request
  always_comb
  begin
    le_stat_next   = lookup_engine_irq;
    port_stat_next = port_irq_pending;
    // Active-low request; masks hold inverted enable sense
    irq_n_next = ~((le_stat_reg & ~glb_mask_reg)
                   | (|(port_stat_reg & ~port_mask_reg)));
  end

  // Power event pin: asserted level follows polarity, idle level otherwise
  always_comb
  begin
    pwr_oe_next = pwr_ctl_reg[PWR_EN_BIT];
    if (pwr_ctl_reg[PWR_EN_BIT] && power_event_req)
    begin
      pwr_pin_next = pwr_ctl_reg[PWR_POL_BIT];
    end
    else
    begin
      pwr_pin_next = ~pwr_ctl_reg[PWR_POL_BIT];
    end
  end

  // Preamble option goes only to the management data interface
  always_comb
  begin
    preamble_next = sio_ctl_reg[SIO_PRE_BIT];
  end

  // Serial clock period in ref_clk cycles; sampling at 100 MHz makes the
  // threshold coarse, so rates near 25 MHz may resolve either way
  always_comb
  begin
    per_cnt_next = per_cnt_reg;
    fast_next    = fast_reg;
    if (acc.sclk_rise)
    begin
      per_cnt_next = 4'h0;
      fast_next    = (per_cnt_reg < SCLK_FAST_CYC);
    end
    else if (per_cnt_reg != 4'hF)
    begin
      per_cnt_next = per_cnt_reg + 4'h1;
    end
    if (sio_ctl_reg[SIO_AUTO_BIT])
    begin
      launch_rise_next = fast_reg;
    end
    else
    begin
      launch_rise_next = sio_ctl_reg[SIO_RISE_BIT];
    end
  end

  assign acc.launch_rise = launch_rise_reg;

  // All state registers
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pwr_ctl_reg     <= PWR_CTL_RST;
      glb_mask_reg    <= GLB_MASK_RST;
      port_mask_reg   <= PORT_MASK_RST;
      sio_ctl_reg     <= SIO_CTL_RST;

      // Cleared status, idle pins
      le_stat_reg     <= 1'b0;
      port_stat_reg   <= 3'h0;
      irq_n_reg       <= 1'b1;
      pwr_pin_reg     <= 1'b1;
      pwr_oe_reg      <= 1'b0;
      preamble_reg    <= 1'b0;

      per_cnt_reg     <= 4'hF;
      fast_reg        <= 1'b0;
      launch_rise_reg <= 1'b0;
    end
    else
    begin
      pwr_ctl_reg     <= pwr_ctl_next;
      glb_mask_reg    <= glb_mask_next;
      port_mask_reg   <= port_mask_next;
      sio_ctl_reg     <= sio_ctl_next;

      le_stat_reg     <= le_stat_next;
      port_stat_reg   <= port_stat_next;
      irq_n_reg       <= irq_n_next;
      pwr_pin_reg     <= pwr_pin_next;
      pwr_oe_reg      <= pwr_oe_next;
      preamble_reg    <= preamble_next;

      per_cnt_reg     <= per_cnt_next;
      fast_reg        <= fast_next;
      launch_rise_reg <= launch_rise_next;
    end
  end

  // Top outputs straight from flops
  assign irq_n              = irq_n_reg;
  assign power_event_pin    = pwr_pin_reg;
  assign power_event_pin_oe = pwr_oe_reg;
  assign preamble_suppress  = preamble_reg;

endmodule

`default_nettype wire

// *** test/global_irq_serial_ctrl_monitor.sv ***
/* Checker for global_irq_serial_ctrl: output timing tied to inputs.
   Assumes one ref_clk domain; bound to the top module below. */
`timescale 1ns/1ps
`default_nettype none
module global_irq_serial_ctrl_monitor (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       arst_n,
  // Watched inputs
  input wire logic       spi_sclk,
  input wire logic       spi_cs_n,
  input wire logic       lookup_engine_irq,
  input wire logic [2:0] port_irq_pending,
  input wire logic       power_event_req,
  // Watched outputs
  input wire logic       serial_data_out,
  input wire logic       serial_data_out_oe,
  input wire logic       irq_n,
  input wire logic       power_event_pin,
  input wire logic       power_event_pin_oe,
  input wire logic       preamble_suppress
);
  logic [3:0] idle_reg;
  logic [3:0] idle_next;
  logic       quiet;
  // Idle select count; config only moves inside frames
  always_comb
  begin
    idle_next = spi_cs_n ? idle_reg + {3'h0, idle_reg != 4'hF} : 4'h0;
  end
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      idle_reg <= 4'h0;
    else
      idle_reg <= idle_next;
  end
  assign quiet = idle_reg > 4'h9;  // Margin covers write landing lag
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_no_src; (!lookup_engine_irq && port_irq_pending == 3'h0)[*2]; endsequence
  sequence s_src_hold; (quiet && $stable(lookup_engine_irq) && $stable(port_irq_pending))[*3]; endsequence
  sequence s_pins_hold; ($stable(spi_sclk) && $stable(spi_cs_n))[*8]; endsequence
  property p_irq_idle; s_no_src |=> irq_n; endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("irq_n low without source");
  property p_irq_hold; s_src_hold |-> $stable(irq_n); endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq_n moved with steady sources");
  property p_pin_follow; quiet && power_event_pin_oe |-> $changed(power_event_pin) ==
    ($past(power_event_req) != $past(power_event_req, 2)); endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("power pin not following request");
  property p_pin_idle; quiet && !power_event_pin_oe |-> $stable(power_event_pin); endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("disabled power pin moved");
  property p_oe_hold; quiet |-> $stable(power_event_pin_oe); endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("power pin enable moved outside frame");
  property p_pre_hold; quiet |-> $stable(preamble_suppress); endproperty
  a_pre_hold: assert property (p_pre_hold) else $error("preamble option moved outside frame");
  property p_sdo_off; spi_cs_n[*5] |-> !serial_data_out_oe; endproperty
  a_sdo_off: assert property (p_sdo_off) else $error("data out driven while deselected");
  property p_sdo_hold; s_pins_hold |-> $stable(serial_data_out); endproperty
  a_sdo_hold: assert property (p_sdo_hold) else $error("data out moved between clock edges");
endmodule

bind global_irq_serial_ctrl global_irq_serial_ctrl_monitor u_monitor (
  .ref_clk(ref_clk), .arst_n(arst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
  .lookup_engine_irq(lookup_engine_irq), .port_irq_pending(port_irq_pending),
  .power_event_req(power_event_req), .serial_data_out(serial_data_out),
  .serial_data_out_oe(serial_data_out_oe), .irq_n(irq_n), .power_event_pin(power_event_pin),
  .power_event_pin_oe(power_event_pin_oe), .preamble_suppress(preamble_suppress));
`default_nettype wire

// *** test/spi_host_model.sv ***
/* Host serial master model: byte-addressed frames, MSB first.
   Assumes a 100 MHz ref_clk for pacing a 160 ns serial clock. */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // Pacing clock
  input  wire logic ref_clk,
  // Serial pins
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_sdi,
  input  wire logic serial_data_out,
  input  wire logic serial_data_out_oe
);
  int edge_hi;
  int edge_lo;
  // Idle pins; clock stands low outside frames
  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
    edge_hi = 0;
    edge_lo = 0;
  end
  // Classify each launch by clock level to tell the edge used
  always @(serial_data_out)
    if (!spi_cs_n && serial_data_out_oe)
      if (spi_sclk)
        edge_hi++;
      else
        edge_lo++;
  task automatic half;
    repeat (8) @(negedge ref_clk);
  endtask
  // Header then one data byte; read bits sampled before each rise
  task automatic xfer(input logic rd, input logic [15:0] addr, input logic [7:0] wd, output logic [7:0] rdat);
    logic [31:0] frame;
    frame = {rd, 7'h00, addr, wd};
    spi_cs_n = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      spi_sdi = frame[i];
      half;
      if (i < 8)
        rdat[i] = serial_data_out_oe ? serial_data_out : ~serial_data_out;
      spi_sclk = 1'b1;
      half;
      spi_sclk = 1'b0;
    end
    half;
    spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi;  // Released line has no pull
    repeat (6) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

// *** test/global_irq_serial_ctrl_tb.sv ***
/* Self-checking bench for global_irq_serial_ctrl through a host model.
   Assumes the host model owns the serial pins; events come from an LFSR. */
`timescale 1ns/1ps
`default_nettype none
module global_irq_serial_ctrl_tb
  import switch_glb_pkg::*;
;
  localparam logic [7:0] VARIANT = 8'h3C;  // Arbitrary value
  logic        ref_clk, arst_n, spi_sclk, spi_cs_n, spi_sdi, serial_data_out, serial_data_out_oe;
  logic        lookup_engine_irq, power_event_req, irq_n, power_event_pin, power_event_pin_oe;
  logic        preamble_suppress, m_gmask;
  logic [2:0]  port_irq_pending, m_pmask;
  logic [1:0]  m_pwr;
  logic [7:0]  m_sio, v;
  logic [31:0] lfsr;
  logic [15:0] addr_q[$];
  logic [2:0]  mode_q[$];
  int          err_count, tests_run;
  // 100 MHz reference clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  global_irq_serial_ctrl #(.PRODUCT_VARIANT(VARIANT)) DUT (
    .ref_clk(ref_clk), .arst_n(arst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
    .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
    .lookup_engine_irq(lookup_engine_irq), .port_irq_pending(port_irq_pending),
    .power_event_req(power_event_req), .irq_n(irq_n), .power_event_pin(power_event_pin),
    .power_event_pin_oe(power_event_pin_oe), .preamble_suppress(preamble_suppress));
  spi_host_model host (
    .ref_clk(ref_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
    .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe));
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected byte from the model state and live sources
  function automatic logic [7:0] exp_byte(input logic [15:0] a);
    case (a)
      ADDR_PWR_CTL:  return {6'h00, m_pwr};
      ADDR_VARIANT:  return VARIANT;
      ADDR_GLB_STAT: return {lookup_engine_irq, 7'h00};
      ADDR_GLB_MASK: return {m_gmask, 7'h00};
      16'h001B:      return {5'h00, port_irq_pending};
      16'h001F:      return {5'h00, m_pmask};
      ADDR_SIO_CTL:  return m_sio;
      default:       return 8'h00;
    endcase
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic do_reset;
    arst_n = 1'b0;
    repeat (20) @(negedge ref_clk);
    arst_n = 1'b1;
    {m_pwr, m_gmask, m_pmask, m_sio} = {PWR_CTL_RST, GLB_MASK_RST, PORT_MASK_RST, SIO_CTL_RST};
    repeat (4) @(negedge ref_clk);
  endtask
  // Register writes update the model only where bits are writable
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] unused;
    host.xfer(1'b0, a, d, unused);
    case (a)
      ADDR_PWR_CTL:  m_pwr = d[1:0];
      ADDR_GLB_MASK: m_gmask = d[7];
      16'h001F:      m_pmask = d[2:0];
      ADDR_SIO_CTL:  m_sio = d;
      default:       ;
    endcase
  endtask
  task automatic rd_chk(input logic [15:0] a);
    host.xfer(1'b1, a, 8'h00, v);
    check(v, exp_byte(a), "read byte");
  endtask
  task automatic rand_src;
    @(negedge ref_clk);
    repeat (5) lfsr = lfsr_step(lfsr);
    {lookup_engine_irq, port_irq_pending, power_event_req} = lfsr[4:0];
  endtask
  // Pins once sources settle; irq path is two cycles
  task automatic pins_chk;
    logic pin, irq;
    repeat (3) @(negedge ref_clk);
    pin = m_pwr[1] ? ~(power_event_req ^ m_pwr[0]) : ~m_pwr[0];
    irq = (lookup_engine_irq & ~m_gmask) | |(port_irq_pending & ~m_pmask);
    check({4'h0, power_event_pin_oe, power_event_pin, irq_n, preamble_suppress},
          {4'h0, m_pwr[1], pin, ~irq, m_sio[2]}, "pins");
  endtask
  // Hang guard, about 1.7 times the run
  initial
  begin
    #900_000;
    err_count++;
    tally_and_finish;
  end
  initial
  begin
    arst_n = 1'b0;
    {lookup_engine_irq, port_irq_pending, power_event_req} = 5'h00;
    lfsr = 32'h0000_05CF;
    err_count = 0;
    tests_run = 0;
    addr_q = {ADDR_PWR_CTL, ADDR_VARIANT, ADDR_GLB_STAT, ADDR_GLB_MASK, 16'h001B, 16'h001F, ADDR_SIO_CTL};
    mode_q = {3'b110, 3'b000, 3'b101, 3'b011, 3'b010};
    do_reset;
    // Reset values of every register
    pins_chk;
    foreach (addr_q[i])
      rd_chk(addr_q[i]);
    $display("test reset_values done");
    // Read-only, unused and unmapped bytes ignore writes
    for (int a = 15; a < 32; a++)
      if (a != 20 && a != 31)
        wr(16'(a), 8'hFF);
    wr(16'h0200, 8'hFF);
    for (int a = 15; a < 32; a++)
      rd_chk(16'(a));
    rd_chk(16'h0200);
    $display("test read_only done");
    // Random masks and sources; mixed mask byte by read-merge-write
    repeat (6)
    begin
      rd_chk(16'h001F);
      rd_chk(ADDR_GLB_MASK);
      repeat (5) lfsr = lfsr_step(lfsr);
      wr(ADDR_GLB_MASK, {lfsr[7], v[6:0]});
      wr(16'h001F, lfsr[15:8]);
      repeat (4)
      begin
        rand_src;
        pins_chk;
      end
      rd_chk(ADDR_GLB_STAT);
      rd_chk(16'h001B);
    end
    $display("test interrupts done");
    // Every enable and polarity pairing of the power event pin
    for (int p = 0; p < 4; p++)
    begin
      repeat (5) lfsr = lfsr_step(lfsr);
      wr(ADDR_PWR_CTL, {lfsr[5:0], 2'(p)});
      repeat (3)
      begin
        rand_src;
        pins_chk;
      end
      rd_chk(ADDR_PWR_CTL);
    end
    $display("test power_pin done");
    // Launch edge and preamble modes; auto is falling here
    foreach (mode_q[i])
    begin
      rd_chk(ADDR_SIO_CTL);
      wr(ADDR_SIO_CTL, {v[7:3], mode_q[i]});
      host.edge_hi = 0;
      host.edge_lo = 0;
      rd_chk(ADDR_SIO_CTL);
      check({7'h0, host.edge_hi > 0}, {7'h0, mode_q[i][1:0] == 2'b01}, "rise launch");
      check({7'h0, host.edge_lo > 0}, {7'h0, mode_q[i][1:0] != 2'b01}, "fall launch");
      pins_chk;
    end
    $display("test serial_modes done");
    // Second reset mid-run restores defaults
    wr(ADDR_PWR_CTL, 8'h03);
    do_reset;
    pins_chk;
    rd_chk(ADDR_SIO_CTL);
    $display("test second_reset done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
